// [common/dma_chan_defs.svh]
// constants of the per-channel control and status block
// assumes inclusion by bare name from the package and the design file
`ifndef DMA_CHAN_DEFS_SVH
`define DMA_CHAN_DEFS_SVH

`define ADDR_W            8
`define OFS_CTRL_B        8'h44
`define OFS_IRQ_EN_CLR    8'h4c
`define OFS_IRQ_EN_SET    8'h4d
`define OFS_IRQ_FLAGS     8'h4e
`define OFS_STATE         8'h4f
`define OFS_DESC_INFO     8'h50
`define BIT_PAUSE         2
`define BIT_DONE          1
`define BIT_FAULT         0
`define BIT_FETCH_FAULT   2
`define BIT_BUSY          1
`define BIT_WAITING       0
`define BIT_EV_ALLOW      3
`define EV_BEH_HI         2
`define CMD_LO            24
`define CMD_HI            25
`define FLAG_W            3
`define RESET_BYTE        8'h00
`define DESC_STRIDE_SHIFT 4

`endif

// [common/dma_chan_pkg.sv]
// types of the per-channel control and status block
// assumes the defs header is on the include path
`include "dma_chan_defs.svh"
`default_nettype none
package dma_chan_pkg;
   // event input behaviour encodings
   typedef enum logic [2:0] {
      no_action                = 3'h0,
      periodic_start_action    = 3'h1,
      conditional_start_action = 3'h2,
      conditional_block_action = 3'h3,
      ev_pause                 = 3'h4,
      ev_resume                = 3'h5,
      skip_next_pause          = 3'h6,
      ev_reserved              = 3'h7
   } event_in_behavior_e;

   // software command encodings
   typedef enum logic [1:0] {
      cmd_none   = 2'h0,
      cmd_pause  = 2'h1,
      cmd_resume = 2'h2,
      cmd_rsvd   = 2'h3
   } sw_command_e;

   // after block behaviour encodings
   typedef enum logic [1:0] {
      blk_none       = 2'h0,
      blk_irq        = 2'h1,
      blk_pause      = 2'h2,
      blk_pause_irq  = 2'h3
   } after_block_behavior_e;

   // channel activity, gray coded along idle, waiting, busy, paused
   typedef enum logic [1:0] {
      st_idle    = 2'b00,
      st_waiting = 2'b01,
      st_busy    = 2'b11,
      st_paused  = 2'b10
   } chan_state_e;
endpackage
`default_nettype wire

// [hdl/dma_chan_ctl.sv]
// per-channel event handling, interrupt enables, flags and status of a dma channel
// assumes the datapath reports beat/block/fetch events as one-cycle pulses on clk
//
// Behaviour
// [RULE1] with event allow clear all events are ignored, else configured action runs
// [RULE2] behaviour codes 1..3 give periodic, conditional and conditional block starts
// [RULE3] codes 4,5,6 pause, resume, skip next pause; code 7 does nothing
// [RULE4] allow bit and behaviour field exist only when built with event input
// [RULE5] clear view: writing one clears an enable, zero ignored, reads enables
// [RULE6] set view: writing one sets an enable, zero ignored, reads enables
// [RULE7] both views share pause bit2, done bit1, fault bit0 enables
// [RULE8] unused upper bits of enable, flag, status registers read zero
// [RULE9] writing one clears a flag, zero leaves it
// [RULE10] pause flag on pause block action, sw pause, pause event, bad descriptor
// [RULE11] done flag on block end with interrupt block action, never for none
// [RULE12] fault flag on beat bus error or invalid descriptor fetch
// [RULE13] descriptor fault status set on invalid fetch, cleared by sw resume
// [RULE14] busy set on transfer start, cleared on action end, bus error, disable
// [RULE15] waiting set on pending transfer, cleared on start, bus error, disable
// [RULE16] descriptor address is base plus channel number times 0x10
// [RULE17] sw command 1 pauses, 2 resumes, 0 and 3 do nothing
// [RULE18] block action 1 irq, 2 pause, 3 both, 0 nothing
// [RULE19] irq request high while any flag and its enable are both set
`include "dma_chan_defs.svh"
`default_nettype none
module dma_chan_ctl #(
   parameter int          CHAN_NUM     = 0,
   parameter bit          HAS_EVENT_IN = 1'b1
) (
   // clock and reset
   input  wire logic                             clk,
   input  wire logic                             rst,
   // register port
   input  wire logic [`ADDR_W-1:0]               reg_addr,
   input  wire logic [31:0]                      reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output logic      [31:0]                      reg_rdata,
   // channel enable from the controller
   input  wire logic                             chan_enable,
   // event input from the routing fabric, same clock
   input  wire logic                             event_in,
   // datapath reports
   input  wire logic                             trigger_pending,
   input  wire logic                             transfer_start,
   input  wire logic                             action_done,
   input  wire logic                             beat_bus_error,
   input  wire logic                             block_done,
   input  wire dma_chan_pkg::after_block_behavior_e after_block_behavior,
   input  wire logic                             desc_invalid,
   input  wire logic [31:0]                      descriptor_table_base,
   input  wire logic [31:0]                      writeback_area_base,
   // requests to the datapath
   output logic                                  start_periodic,
   output logic                                  start_conditional,
   output logic                                  start_cond_block,
   output logic                                  chan_paused,
   output logic                                  pause_skip_armed,
   output logic [31:0]                           desc_addr,
   output logic [31:0]                           writeback_addr,
   // interrupt request
   output logic                                  irq
);
   import dma_chan_pkg::*;

   logic [`FLAG_W-1:0] irq_en;
   logic [`FLAG_W-1:0] flags;
   logic               fetch_fault;
   logic               busy;
   logic               waiting;
   logic               event_in_allow;
   event_in_behavior_e event_in_behavior;
   logic [31:0]        rdata_q;
   logic [`FLAG_W-1:0] next_irq_en;
   logic [`FLAG_W-1:0] next_flags;
   chan_state_e        chan_state_q;
   chan_state_e        next_chan_state;

   // 32-bit wide view of a field at the low bits, upper bits zero
   function automatic logic [31:0] low3(input logic [`FLAG_W-1:0] v);
      low3 = {29'h0000000, v};
   endfunction

   // channel stride into the descriptor tables
   function automatic logic [31:0] chan_ofs(input int unsigned n);
      chan_ofs = 32'(n) << `DESC_STRIDE_SHIFT;
   endfunction

   // address decode
   wire hit_ctrl   = reg_addr == `OFS_CTRL_B;
   wire hit_en_clr = reg_addr == `OFS_IRQ_EN_CLR;
   wire hit_en_set = reg_addr == `OFS_IRQ_EN_SET;
   wire hit_flags  = reg_addr == `OFS_IRQ_FLAGS;
   wire hit_state  = reg_addr == `OFS_STATE;
   wire hit_desc   = reg_addr == `OFS_DESC_INFO;
   wire [`FLAG_W-1:0] wbits = reg_wdata[`FLAG_W-1:0];

   // software command, acts only in the write cycle
   wire [1:0] cmd_field = reg_wdata[`CMD_HI:`CMD_LO];
   wire sw_pause  = reg_wr && hit_ctrl && cmd_field == cmd_pause;   // RULE17
   wire sw_resume = reg_wr && hit_ctrl && cmd_field == cmd_resume;  // RULE17

   // event decode; allow and behaviour are constant zero without event input
   wire ev_fire = event_in && event_in_allow;                                  // RULE1
   assign start_periodic    = ev_fire && event_in_behavior == periodic_start_action;  // RULE2
   assign start_conditional = ev_fire && event_in_behavior == conditional_start_action; // RULE2
   assign start_cond_block  = ev_fire && event_in_behavior == conditional_block_action; // RULE2
   wire evt_pause  = ev_fire && event_in_behavior == ev_pause;                 // RULE3
   wire evt_resume = ev_fire && event_in_behavior == ev_resume;                // RULE3
   wire ev_skip   = ev_fire && event_in_behavior == skip_next_pause;           // RULE3

   // block end outcome; a skip armed earlier swallows one pause action
   wire blk_wants_pause = block_done &&
                          (after_block_behavior == blk_pause ||
                           after_block_behavior == blk_pause_irq);             // RULE18
   wire blk_pause_now   = blk_wants_pause && !pause_skip_armed;
   wire blk_irq_now     = block_done &&
                          (after_block_behavior == blk_irq ||
                           after_block_behavior == blk_pause_irq);             // RULE11

   // flag set sources
   wire set_pause = blk_pause_now || sw_pause || evt_pause || desc_invalid;   // RULE10
   wire set_done  = blk_irq_now;                                              // RULE11
   wire set_fault = beat_bus_error || desc_invalid;                           // RULE12
   wire [`FLAG_W-1:0] flag_set = {set_pause, set_done, set_fault};
   wire [`FLAG_W-1:0] flag_clr = (reg_wr && hit_flags) ? wbits : `FLAG_W'(0); // RULE9

   // enables shared by both views
   always_comb begin
      next_irq_en = irq_en;
      if (reg_wr && hit_en_clr) begin
         next_irq_en = irq_en & ~wbits;           // RULE5 RULE7
      end else if (reg_wr && hit_en_set) begin
         next_irq_en = irq_en | wbits;            // RULE6 RULE7
      end
   end

   // a hardware set in the clearing cycle wins so no event is lost
   assign next_flags = (flags & ~flag_clr) | flag_set;   // RULE9

   // channel activity, pause/resume take priority over start/finish
   always_comb begin
      next_chan_state = chan_state_q;
      if (!chan_enable || beat_bus_error) begin
         next_chan_state = st_idle;                       // RULE14 RULE15
      end else if (set_pause) begin
         next_chan_state = st_paused;
      end else begin
         case (chan_state_q)
            st_idle: begin
               if (transfer_start) begin
                  next_chan_state = st_busy;              // RULE14
               end else if (trigger_pending) begin
                  next_chan_state = st_waiting;           // RULE15
               end
            end
            st_waiting: begin
               if (transfer_start) begin
                  next_chan_state = st_busy;              // RULE15
               end
            end
            st_busy: begin
               if (action_done) begin
                  next_chan_state = trigger_pending ? st_waiting : st_idle; // RULE14
               end
            end
            st_paused: begin
               if (sw_resume || evt_resume) begin
                  next_chan_state = st_idle;
               end
            end
            default: next_chan_state = st_idle;
         endcase
      end
   end

   assign busy        = chan_state_q == st_busy;
   assign waiting     = chan_state_q == st_waiting;
   assign chan_paused = chan_state_q == st_paused;

   // enables and flags
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_en <= `FLAG_W'(`RESET_BYTE);
         flags  <= `FLAG_W'(`RESET_BYTE);
      end else begin
         irq_en <= next_irq_en;
         flags  <= next_flags;
      end
   end

   // channel state register
   always_ff @(posedge clk) begin
      if (rst) begin
         chan_state_q <= st_idle;
      end else begin
         chan_state_q <= next_chan_state;
      end
   end

   // fetch fault: set beats clear since an invalid fetch also pauses
   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_fault <= 1'b0;
      end else if (desc_invalid) begin
         fetch_fault <= 1'b1;                    // RULE13
      end else if (sw_resume) begin
         fetch_fault <= 1'b0;                    // RULE13
      end
   end

   // skip arm: set by event, consumed by the next pause block action
   always_ff @(posedge clk) begin
      if (rst || !chan_enable) begin
         pause_skip_armed <= 1'b0;
      end else if (ev_skip) begin
         pause_skip_armed <= 1'b1;               // RULE3
      end else if (blk_wants_pause) begin
         pause_skip_armed <= 1'b0;
      end
   end

   // event configuration only exists when built with event input
   generate
      if (HAS_EVENT_IN) begin : g_ev
         always_ff @(posedge clk) begin
            if (rst) begin
               event_in_allow    <= 1'b0;
               event_in_behavior <= no_action;
            end else if (reg_wr && hit_ctrl) begin
               event_in_allow    <= reg_wdata[`BIT_EV_ALLOW];                       // RULE4
               event_in_behavior <= event_in_behavior_e'(reg_wdata[`EV_BEH_HI:0]);  // RULE4
            end
         end
      end else begin : g_no_ev
         assign event_in_allow    = 1'b0;        // RULE4
         assign event_in_behavior = no_action;   // RULE4
      end
   endgenerate

   // descriptor placement in memory
   assign desc_addr      = descriptor_table_base + chan_ofs(CHAN_NUM); // RULE16
   assign writeback_addr = writeback_area_base + chan_ofs(CHAN_NUM);   // RULE16

   // interrupt request; combinational from flag and enable flops
   assign irq = |(flags & irq_en);               // RULE19

   // read mux, unused upper bits read zero
   wire [`FLAG_W-1:0] state_bits = {fetch_fault, busy, waiting};
   wire [31:0] ctrl_view = {28'h0000000, event_in_allow, event_in_behavior};
   wire [31:0] rd_mux =
      hit_ctrl                  ? ctrl_view :
      (hit_en_clr | hit_en_set) ? low3(irq_en) :       // RULE8
      hit_flags                 ? low3(flags) :        // RULE8
      hit_state                 ? low3(state_bits) :   // RULE8
      hit_desc                  ? chan_ofs(CHAN_NUM) : 32'h00000000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      end
   end
   assign reg_rdata = rdata_q;

   // checks
   a_flag_set_wins: assert property (@(posedge clk) disable iff (rst)
      set_pause |=> flags[`BIT_PAUSE]) else $error("pause flag lost"); // RULE10
   a_done_none: assert property (@(posedge clk) disable iff (rst)
      block_done && after_block_behavior == blk_none && !flags[`BIT_DONE]
      && !(reg_wr && hit_flags) |=> !flags[`BIT_DONE]) else $error("done flag on no action"); // RULE11
   a_fault_flag_set: assert property (@(posedge clk) disable iff (rst)
      beat_bus_error |=> flags[`BIT_FAULT] && !busy && !waiting) else $error("fault"); // RULE12
   a_w1c_flags: assert property (@(posedge clk) disable iff (rst)
      reg_wr && hit_flags && reg_wdata[`BIT_DONE] && !set_done |=> !flags[`BIT_DONE])
      else $error("flag not cleared"); // RULE9
   a_en_clear_view: assert property (@(posedge clk) disable iff (rst)
      reg_wr && hit_en_clr |=> irq_en == ($past(irq_en) & ~$past(wbits)))
      else $error("enable clear wrong"); // RULE5
   a_en_set_view: assert property (@(posedge clk) disable iff (rst)
      reg_wr && hit_en_set |=> irq_en == ($past(irq_en) | $past(wbits)))
      else $error("enable set wrong"); // RULE6
   a_ignore_events: assert property (@(posedge clk) disable iff (rst)
      !event_in_allow |-> !start_periodic && !start_conditional && !start_cond_block)
      else $error("event not ignored"); // RULE1
   a_fetch_fault: assert property (@(posedge clk) disable iff (rst)
      desc_invalid |=> fetch_fault && chan_paused) else $error("fetch fault"); // RULE13
   a_upper_zero: assert property (@(posedge clk) disable iff (rst)
      reg_rd && (hit_flags || hit_state || hit_en_set) |=> reg_rdata[31:`FLAG_W] == 0)
      else $error("upper bits set"); // RULE8
   a_irq_pair: assert property (@(posedge clk) disable iff (rst)
      $rose(flags[`BIT_FAULT]) && irq_en[`BIT_FAULT] |-> irq) else $error("irq missing"); // RULE19
   a_busy_disable: assert property (@(posedge clk) disable iff (rst)
      !chan_enable |=> !busy && !waiting) else $error("busy after disable"); // RULE14
endmodule
`default_nettype wire

// [bench/dma_far_side_model.sv]
// far side model: event fabric and transfer datapath reporting to the channel
// assumes the bench asks for pulses one cycle ahead on the same clock
`default_nettype none
module dma_far_side_model #(
   parameter logic [31:0] TABLE_BASE = 32'h2000_0100,
   parameter logic [31:0] WB_BASE    = 32'h2000_0400
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // requests from the bench: ev, start, done, err, blk, bad
   input  wire logic [5:0]            req,
   input  wire logic                  transfer_waiting_req,
   input  wire logic [1:0]            blk_req,
   // towards the channel
   output logic                       event_in,
   output logic                       transfer_start,
   output logic                       action_done,
   output logic                       beat_bus_error,
   output logic                       block_done,
   output logic                       desc_invalid,
   output logic                       trigger_pending,
   output var dma_chan_pkg::after_block_behavior_e after_block_behavior,
   output logic [31:0]                descriptor_table_base,
   output logic [31:0]                writeback_area_base
);
   timeunit 1ns;
   timeprecision 100ps;
   import dma_chan_pkg::*;
   assign descriptor_table_base = TABLE_BASE;
   assign writeback_area_base   = WB_BASE;
   // the six reports in req are one-cycle pulses, trigger_pending follows its level; the block action travels beside block_done
   always_ff @(posedge clk) begin
      if (rst) begin
         {desc_invalid, block_done, beat_bus_error, action_done, transfer_start, event_in} <= '0;
         trigger_pending      <= 1'b0;
         after_block_behavior <= blk_none;
      end else begin
         {desc_invalid, block_done, beat_bus_error, action_done, transfer_start, event_in} <= req;
         trigger_pending      <= transfer_waiting_req;
         after_block_behavior <= after_block_behavior_e'(blk_req);
      end
   end
endmodule
`default_nettype wire

// [bench/dma_channel_event_irq_status_tb_top.sv]
// bench for the channel control block: register tasks and event/datapath pulses
// assumes the far side model sits between the bench and the channel inputs
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
   $display("CHECK FAILED t=%0t %s", $time, msg); end end
module dma_channel_event_irq_status_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dma_chan_pkg::*;
   localparam int CH = 3;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        chan_enable = 1'b1;
   logic [5:0]  req = '0;
   logic        transfer_waiting_req = 1'b0;
   logic [1:0]  blk_req = '0;
   logic        ev, ts, ad, be, bd, di, tp;
   after_block_behavior_e abb;
   logic [31:0] tbase, wbase, desc_addr, wb_addr;
   logic        s_per, s_cond, s_blk, chan_paused, skip_armed, irq;
   logic [2:0]  sv;
   logic [31:0] rd;
   logic [31:0] rdata_ne;
   int          fails = 0;
   int          cmp_count = 0;

   always #12.5 clk = ~clk;

   dma_far_side_model far (.clk(clk), .rst(rst), .req(req), .transfer_waiting_req(transfer_waiting_req),
      .blk_req(blk_req), .event_in(ev), .transfer_start(ts), .action_done(ad),
      .beat_bus_error(be), .block_done(bd), .desc_invalid(di), .trigger_pending(tp),
      .after_block_behavior(abb), .descriptor_table_base(tbase), .writeback_area_base(wbase));

   dma_chan_ctl #(.CHAN_NUM(CH), .HAS_EVENT_IN(1'b1)) dut (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .chan_enable(chan_enable), .event_in(ev), .trigger_pending(tp),
      .transfer_start(ts), .action_done(ad), .beat_bus_error(be), .block_done(bd),
      .after_block_behavior(abb), .desc_invalid(di), .descriptor_table_base(tbase),
      .writeback_area_base(wbase), .start_periodic(s_per), .start_conditional(s_cond),
      .start_cond_block(s_blk), .chan_paused(chan_paused), .pause_skip_armed(skip_armed),
      .desc_addr(desc_addr), .writeback_addr(wb_addr), .irq(irq));

   // channel built without event input: sees the same bus, its control view stays zero
   dma_chan_ctl #(.CHAN_NUM(0), .HAS_EVENT_IN(1'b0)) dut_no_ev (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(rdata_ne), .chan_enable(chan_enable), .event_in(ev), .trigger_pending(tp),
      .transfer_start(ts), .action_done(ad), .beat_bus_error(be), .block_done(bd),
      .after_block_behavior(abb), .desc_invalid(di), .descriptor_table_base(tbase),
      .writeback_area_base(wbase), .start_periodic(), .start_conditional(),
      .start_cond_block(), .chan_paused(), .pause_skip_armed(), .desc_addr(),
      .writeback_addr(), .irq());

   // one-cycle write strobe beside address and data
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // step off the edge so direct checks see the state the write launched
      #1;
   endtask

   // read data stands only in the cycle after the strobe, so sample it there
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
      `CHK(rd, e, m)
   endtask

   // one far side pulse; start requests are combinational, caught while the pulse stands
   task automatic pulse(input int idx);
      @(posedge clk);
      req <= 6'h01 << idx;
      @(posedge clk);
      req <= '0;
      #1 sv = {s_blk, s_cond, s_per};
      @(posedge clk);
      #1;
   endtask

   task automatic done_test(input string n);
      $display("test %s finished", n);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hang guard: a bounded count of cycles for the whole run
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      close_out();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // reset values and the descriptor stride
      rd_chk(8'h4c, 32'h0, "enclr reset");
      rd_chk(8'h4d, 32'h0, "enset reset");
      rd_chk(8'h4e, 32'h0, "flags reset");
      rd_chk(8'h4f, 32'h0, "state reset");
      rd_chk(8'h50, CH * 32'h10, "chan info");
      `CHK(desc_addr, tbase + CH * 32'h10, "desc addr")
      `CHK(wb_addr, wbase + CH * 32'h10, "wb addr")
      done_test("reset");
      // shared enable views, upper bits stay zero
      wr(8'h4d, 32'hff);
      rd_chk(8'h4c, 32'h07, "set seen in clr");
      wr(8'h4c, 32'h02);
      rd_chk(8'h4d, 32'h05, "clr seen in set");
      wr(8'h4c, 32'h00);
      wr(8'h4d, 32'h00);
      rd_chk(8'h4c, 32'h05, "zero writes");
      done_test("enables");
      // event actions: gated by allow, then each start code
      wr(8'h44, 32'h01);
      pulse(0);
      `CHK(sv, 3'b000, "event ignored")
      for (int c = 1; c <= 3; c++) begin
         wr(8'h44, 32'h08 | c);
         rd_chk(8'h44, 32'h08 | c, "ctrl readback");
         pulse(0);
         `CHK(sv, 3'b001 << (c - 1), "start code")
      end
      wr(8'h44, 32'h0f);
      pulse(0);
      rd_chk(8'h44, 32'h0f, "ctrl code7");
      `CHK(rdata_ne, 32'h0, "no event input")
      rd_chk(8'h4e, 32'h0, "reserved code");
      `CHK(chan_paused, 1'b0, "reserved no pause")
      wr(8'h44, 32'h0c);
      pulse(0);
      `CHK(chan_paused, 1'b1, "event pause")
      rd_chk(8'h4e, 32'h04, "pause flag event");
      `CHK(irq, 1'b1, "irq on pause")
      wr(8'h4e, 32'h03);
      rd_chk(8'h4e, 32'h04, "w0 keeps flag");
      wr(8'h4e, 32'h04);
      rd_chk(8'h4e, 32'h00, "w1 clears flag");
      `CHK(irq, 1'b0, "irq drops")
      wr(8'h44, 32'h0d);
      pulse(0);
      `CHK(chan_paused, 1'b0, "event resume")
      wr(8'h44, 32'h0e);
      pulse(0);
      `CHK(skip_armed, 1'b1, "skip armed")
      done_test("events");
      // block actions, the first pause one swallowed by the skip
      blk_req <= 2'h2;
      pulse(4);
      `CHK(skip_armed, 1'b0, "skip used")
      `CHK(chan_paused, 1'b0, "skip no pause")
      blk_req <= 2'h0;
      pulse(4);
      rd_chk(8'h4e, 32'h00, "none no flag");
      blk_req <= 2'h1;
      pulse(4);
      rd_chk(8'h4e, 32'h02, "irq action");
      wr(8'h4e, 32'h02);
      blk_req <= 2'h3;
      pulse(4);
      rd_chk(8'h4e, 32'h06, "both action");
      `CHK(chan_paused, 1'b1, "block pause")
      wr(8'h4e, 32'h06);
      wr(8'h44, 32'h0200_0000);
      `CHK(chan_paused, 1'b0, "sw resume")
      done_test("blocks");
      // waiting, busy, bus error and disable
      transfer_waiting_req <= 1'b1;
      @(posedge clk);
      rd_chk(8'h4f, 32'h01, "waiting");
      transfer_waiting_req <= 1'b0;
      pulse(1);
      rd_chk(8'h4f, 32'h02, "busy");
      pulse(3);
      rd_chk(8'h4f, 32'h00, "error idles");
      rd_chk(8'h4e, 32'h01, "fault flag");
      `CHK(irq, 1'b1, "irq on fault")
      wr(8'h4e, 32'h01);
      transfer_waiting_req <= 1'b1;
      pulse(1);
      transfer_waiting_req <= 1'b0;
      pulse(2);
      rd_chk(8'h4f, 32'h00, "done idles");
      transfer_waiting_req <= 1'b1;
      @(posedge clk);
      rd_chk(8'h4f, 32'h01, "waiting again");
      chan_enable <= 1'b0;
      rd_chk(8'h4f, 32'h00, "disable idles");
      transfer_waiting_req <= 1'b0;
      // let the pending level fall before enabling, or the channel re-enters waiting
      @(posedge clk);
      chan_enable <= 1'b1;
      done_test("status");
      // invalid descriptor and software commands
      pulse(5);
      rd_chk(8'h4f, 32'h04, "fetch fault");
      rd_chk(8'h4e, 32'h05, "bad desc flags");
      wr(8'h44, 32'h0100_0000);
      rd_chk(8'h4f, 32'h04, "pause keeps fault");
      wr(8'h44, 32'h0200_0000);
      rd_chk(8'h4f, 32'h00, "resume clears");
      wr(8'h4e, 32'h07);
      wr(8'h44, 32'h0100_0000);
      rd_chk(8'h4e, 32'h04, "sw pause flag");
      `CHK(chan_paused, 1'b1, "sw pause")
      wr(8'h44, 32'h0300_0000);
      `CHK(chan_paused, 1'b1, "cmd3 nothing")
      rd_chk(8'h44, 32'h0, "cmd reads zero");
      wr(8'h4f, 32'hff);
      rd_chk(8'h4f, 32'h00, "state read only");
      rd_chk(8'h60, 32'h0, "unmapped");
      done_test("commands");
      close_out();
   end
endmodule
`undef CHK
`default_nettype wire
